// File: inc/wcr_pkg.sv
// Purpose: shared constants and types of the waveform capture recorder
// Assumes: one system clock, 4 samples per quarter power cycle
// Notes:   buffer holds 64 power cycles of samples
`default_nettype none
package wcr_pkg;
	localparam int SAMP_W       = 16;
	localparam int ADDR_W       = 10;
	localparam int BUF_WORDS    = 1024;
	localparam int NSRC         = 8;
	localparam int FIFO_DEPTH   = 4;
	localparam int QC_PER_CYC   = 4;
	localparam int SAMP_QC_SH   = 2;
	localparam int BASE_CYC     = 8;
	localparam logic [10:0] BASE_LEN = 11'(BASE_CYC * QC_PER_CYC * (1 << SAMP_QC_SH));
	localparam logic [3:0]  SLOT_MAX = 4'h8;
	localparam logic [1:0]  TYPE_8X8 = 2'h0;
	localparam logic        ACQ_RST  = 1'b1;
	localparam logic [7:0]  TEN_RST  = 8'h00;

	typedef struct packed {
		logic [SAMP_W-1:0] data;
	} wcr_sample_t;

	typedef struct packed {
		logic [1:0] rec_type;
		logic [7:0] trig_pos;
		logic       single_shot;
		logic       append;
	} wcr_cfg_t;

	typedef enum logic [1:0] {
		ST_HALT = 2'b00,
		ST_ARM  = 2'b01,
		ST_POST = 2'b10
	} wcr_state_t;
endpackage
`default_nettype wire

// File: core/wcr_fifo.sv
// Purpose: small sample FIFO with valid/ready on both sides
// Assumes: synchronous ports, single clock
// Notes:   in_ready_out is registered, so it lags a pop by one cycle
`default_nettype none
module wcr_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 4
) (
	input  wire logic         mclk_in,
	input  wire logic         nrst_in,
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wp_reg;
	logic [PW-1:0] wp_next;
	logic [PW-1:0] rp_reg;
	logic [PW-1:0] rp_next;
	logic [PW:0]   cnt_reg;
	logic [PW:0]   cnt_next;
	logic          rdy_reg;
	logic          rdy_next;
	logic          push;
	logic          pop;

	assign push          = in_valid_in & rdy_reg;
	assign pop           = out_ready_in & (cnt_reg != '0);
	assign in_ready_out  = rdy_reg;
	assign out_valid_out = (cnt_reg != '0);
	assign out_data_out  = mem[rp_reg];

	always_comb begin
		wp_next  = wp_reg;
		rp_next  = rp_reg;
		cnt_next = cnt_reg;
		if (push) begin
			wp_next = (wp_reg == LAST) ? '0 : wp_reg + 1'b1;
		end
		if (pop) begin
			rp_next = (rp_reg == LAST) ? '0 : rp_reg + 1'b1;
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
		rdy_next = (cnt_next != FULL);
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
			rdy_reg <= 1'b1;
		end else begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem[wp_reg] <= in_data_in;
		end
	end
endmodule
`default_nettype wire

// File: core/wcr_recorder.sv
// Purpose: oscillographic capture buffer split into records with pre-trigger data
// Assumes: samples arrive synchronous to mclk_in, 4 per quarter power cycle
// Notes:   trigger sources are rising-edge qualified; readout stalls sample intake
`default_nettype none
module wcr_recorder (
	input  wire logic                     mclk_in,
	input  wire logic                     nrst_in,
	input  wire wcr_pkg::wcr_sample_t     samp_in,
	input  wire logic                     samp_valid_in,
	output logic                          samp_ready_out,
	input  wire logic [wcr_pkg::NSRC-1:0] trig_src_in,
	input  wire logic [wcr_pkg::NSRC-1:0] trig_en_in,
	input  wire logic                     trig_en_we_in,
	input  wire wcr_pkg::wcr_cfg_t        cfg_in,
	input  wire logic                     start_cmd_in,
	input  wire logic                     stop_cmd_in,
	input  wire logic                     rd_en_in,
	input  wire logic [wcr_pkg::ADDR_W-1:0] rd_addr_in,
	output logic [wcr_pkg::SAMP_W-1:0]    rd_data_out,
	output logic                          acq_active_out,
	output logic                          capturing_out,
	output logic                          rec_done_out,
	output logic [2:0]                    rec_slot_out,
	output logic [3:0]                    rec_used_out,
	output logic [wcr_pkg::ADDR_W-1:0]    rec_start_out,
	output logic [wcr_pkg::NSRC-1:0]      trig_en_out
);
	localparam int AW = wcr_pkg::ADDR_W;
	localparam int SW = wcr_pkg::SAMP_W;
	localparam int NS = wcr_pkg::NSRC;

	logic [SW-1:0]      mem [wcr_pkg::BUF_WORDS];

	wcr_pkg::wcr_sample_t fifo_data;
	logic               fifo_valid;
	logic               fifo_ready;
	logic               wr;

	logic [1:0]         type_reg;
	logic [1:0]         type_next;
	logic               acq_reg;
	logic               acq_next;
	logic [NS-1:0]      en_reg;
	logic [NS-1:0]      en_next;
	logic [NS-1:0]      src_d_reg;
	logic [NS-1:0]      src_d_next;
	wcr_pkg::wcr_state_t state_reg;
	wcr_pkg::wcr_state_t state_next;
	logic               cap_reg;
	logic               cap_next;
	logic               done_reg;
	logic               done_next;
	logic [2:0]         slot_reg;
	logic [2:0]         slot_next;
	logic [3:0]         used_reg;
	logic [3:0]         used_next;
	logic [AW-1:0]      off_reg;
	logic [AW-1:0]      off_next;
	logic [10:0]        fill_reg;
	logic [10:0]        fill_next;
	logic [10:0]        remain_reg;
	logic [10:0]        remain_next;
	logic [AW-1:0]      start_reg;
	logic [AW-1:0]      start_next;
	logic [SW-1:0]      rd_reg;
	logic [SW-1:0]      rd_next;

	logic [10:0]        len;
	logic [3:0]         nslots;
	logic [AW-1:0]      mask;
	logic [AW-1:0]      base;
	logic [7:0]         tp_max;
	logic [7:0]         tp;
	logic [10:0]        pre_want;
	logic [10:0]        pre;
	logic [NS-1:0]      hit;
	logic               trig;
	logic               append_ok;
	logic [3:0]         used_inc;
	logic [2:0]         slot_inc;
	logic               full_after;

	// back-pressure: sample intake pauses while the buffer is being read
	wcr_fifo #(
		.W     ($bits(wcr_pkg::wcr_sample_t)),
		.DEPTH (wcr_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk_in       (mclk_in),
		.nrst_in       (nrst_in),
		.in_valid_in   (samp_valid_in),
		.in_data_in    (samp_in),
		.in_ready_out  (samp_ready_out),
		.out_valid_out (fifo_valid),
		.out_data_out  (fifo_data),
		.out_ready_in  (fifo_ready)
	);

	assign fifo_ready = ~rd_en_in;
	// samples drained while halted are dropped
	assign wr = fifo_valid & fifo_ready & (state_reg != wcr_pkg::ST_HALT);

	// record geometry from the record type
	assign len    = wcr_pkg::BASE_LEN << type_reg;
	assign nslots = wcr_pkg::SLOT_MAX >> type_reg;
	assign mask   = AW'(len - 11'h001);
	assign base   = AW'(len * {8'h00, slot_reg});

	// pre-trigger amount, capped to the layout's maximum and to data on hand
	assign tp_max   = 8'((len >> wcr_pkg::SAMP_QC_SH) - 11'h001);
	assign tp       = (cfg_in.trig_pos > tp_max) ? tp_max : cfg_in.trig_pos;
	assign pre_want = {1'b0, tp, 2'b00};
	assign pre      = (pre_want > fill_reg) ? fill_reg : pre_want;

	// a source held high fires once, on its rising edge
	generate
		for (genvar i = 0; i < NS; i++) begin : g_src
			assign hit[i] = trig_src_in[i] & ~src_d_reg[i] & en_reg[i];
		end
	endgenerate

	assign trig      = |hit;
	assign append_ok = cfg_in.append & (type_reg != wcr_pkg::TYPE_8X8);
	// used saturates once every slot holds a record
	assign used_inc  = (used_reg == nslots) ? used_reg : used_reg + 4'h1;
	assign slot_inc  = ({1'b0, slot_reg} + 4'h1 == nslots) ? 3'h0 : slot_reg + 3'h1;
	assign full_after = (used_reg + 4'h1 >= nslots);

	always_comb begin
		acq_next    = acq_reg;
		state_next  = state_reg;
		done_next   = 1'b0;
		slot_next   = slot_reg;
		used_next   = used_reg;
		off_next    = off_reg;
		fill_next   = fill_reg;
		remain_next = remain_reg;
		start_next  = start_reg;
		// start wins over stop and over a layout change
		if (start_cmd_in) begin
			acq_next   = 1'b1;
			state_next = wcr_pkg::ST_ARM;
			slot_next  = 3'h0;
			used_next  = 4'h0;
			off_next   = '0;
			fill_next  = 11'h000;
		end else if (stop_cmd_in) begin
			acq_next   = 1'b0;
			state_next = wcr_pkg::ST_HALT;
		end else if (cfg_in.rec_type != type_reg) begin
			// a layout change invalidates every stored record
			slot_next  = 3'h0;
			used_next  = 4'h0;
			off_next   = '0;
			fill_next  = 11'h000;
			state_next = acq_reg ? wcr_pkg::ST_ARM : wcr_pkg::ST_HALT;
		end else begin
			case (state_reg)
				wcr_pkg::ST_ARM: begin
					if (wr) begin
						off_next  = (off_reg + 1'b1) & mask;
						fill_next = (fill_reg == len) ? fill_reg : fill_reg + 11'h001;
					end
					if (trig) begin
						start_next  = (off_reg - AW'(pre)) & mask;
						remain_next = len - pre - {10'h000, wr};
						state_next  = wcr_pkg::ST_POST;
					end
				end
				wcr_pkg::ST_POST: begin
					if (trig && append_ok) begin
						// close the running record and open the next slot
						done_next   = 1'b1;
						used_next   = used_inc;
						slot_next   = slot_inc;
						off_next    = '0;
						start_next  = '0;
						remain_next = len;
						fill_next   = 11'h000;
						if (cfg_in.single_shot && full_after) begin
							acq_next   = 1'b0;
							state_next = wcr_pkg::ST_HALT;
						end
					end else if (wr) begin
						// further triggers are ignored here
						off_next    = (off_reg + 1'b1) & mask;
						remain_next = remain_reg - 11'h001;
						if (remain_reg == 11'h001) begin
							done_next  = 1'b1;
							used_next  = used_inc;
							slot_next  = slot_inc;
							off_next   = '0;
							fill_next  = 11'h000;
							state_next = wcr_pkg::ST_ARM;
							if (cfg_in.single_shot && full_after) begin
								acq_next   = 1'b0;
								state_next = wcr_pkg::ST_HALT;
							end
						end
					end
				end
				wcr_pkg::ST_HALT: begin
					state_next = wcr_pkg::ST_HALT;
				end
				default: begin
					state_next = wcr_pkg::ST_HALT;
				end
			endcase
		end
		cap_next = (state_next == wcr_pkg::ST_POST);
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			acq_reg    <= wcr_pkg::ACQ_RST;
			state_reg  <= wcr_pkg::ST_ARM;
			cap_reg    <= 1'b0;
			done_reg   <= 1'b0;
			slot_reg   <= 3'h0;
			used_reg   <= 4'h0;
			off_reg    <= '0;
			fill_reg   <= 11'h000;
			remain_reg <= 11'h000;
			start_reg  <= '0;
		end else begin
			acq_reg    <= acq_next;
			state_reg  <= state_next;
			cap_reg    <= cap_next;
			done_reg   <= done_next;
			slot_reg   <= slot_next;
			used_reg   <= used_next;
			off_reg    <= off_next;
			fill_reg   <= fill_next;
			remain_reg <= remain_next;
			start_reg  <= start_next;
		end
	end

	// settings and trigger edge history
	always_comb begin
		type_next  = cfg_in.rec_type;
		en_next    = trig_en_we_in ? trig_en_in : en_reg;
		src_d_next = trig_src_in;
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			type_reg  <= wcr_pkg::TYPE_8X8;
			en_reg    <= wcr_pkg::TEN_RST;
			src_d_reg <= '0;
		end else begin
			type_reg  <= type_next;
			en_reg    <= en_next;
			src_d_reg <= src_d_next;
		end
	end

	// readout port, data stands until the next read
	always_comb begin
		rd_next = rd_en_in ? mem[rd_addr_in] : rd_reg;
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_reg <= '0;
		end else begin
			rd_reg <= rd_next;
		end
	end

	// sample memory, no reset
	always_ff @(posedge mclk_in) begin
		if (wr) begin
			mem[base | off_reg] <= fifo_data.data;
		end
	end

	assign rd_data_out    = rd_reg;
	assign acq_active_out = acq_reg;
	assign capturing_out  = cap_reg;
	assign rec_done_out   = done_reg;
	assign rec_slot_out   = slot_reg;
	assign rec_used_out   = used_reg;
	assign rec_start_out  = start_reg;
	assign trig_en_out    = en_reg;
endmodule
`default_nettype wire

// File: testbench/wcr_props.sv
// Purpose: port-level assertions for the waveform capture recorder
// Assumes: single clock, asynchronous active-low reset
// Notes:   bound into every recorder instance
`default_nettype none
module wcr_props (
	input wire logic              mclk_in,
	input wire logic              nrst_in,
	input wire logic [7:0]        trig_src_in,
	input wire logic [7:0]        trig_en_in,
	input wire logic              trig_en_we_in,
	input wire wcr_pkg::wcr_cfg_t cfg_in,
	input wire logic              start_cmd_in,
	input wire logic              stop_cmd_in,
	input wire logic              acq_active_out,
	input wire logic              capturing_out,
	input wire logic              rec_done_out,
	input wire logic [2:0]        rec_slot_out,
	input wire logic [3:0]        rec_used_out,
	input wire logic [7:0]        trig_en_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] src_q;
	logic [3:0] nslot;
	logic       trig_hit;
	assign nslot = 4'h8 >> cfg_in.rec_type;
	assign trig_hit = |(trig_src_in & ~src_q & trig_en_out);
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) src_q <= 8'h00;
		else src_q <= trig_src_in;
	end
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);
	// an enabled source rising in this cycle
	sequence s_fire;
		trig_hit;
	endsequence
	property p_rst_state;
		$rose(nrst_in) |-> acq_active_out && trig_en_out == 8'h00;
	endproperty
	property p_en_load;
		trig_en_we_in |=> trig_en_out == $past(trig_en_in);
	endproperty
	property p_en_hold;
		!trig_en_we_in |=> $stable(trig_en_out);
	endproperty
	property p_start_src;
		$rose(capturing_out) |-> $past(trig_hit);
	endproperty
	property p_slot_rng;
		$stable(cfg_in.rec_type) |-> {1'b0, rec_slot_out} < nslot;
	endproperty
	property p_used_rng;
		$stable(cfg_in.rec_type) |-> rec_used_out <= nslot;
	endproperty
	property p_halt_hold;
		!acq_active_out && !start_cmd_in |=> !acq_active_out;
	endproperty
	property p_restart;
		start_cmd_in |=> acq_active_out;
	endproperty
	property p_no_halt;
		acq_active_out && !stop_cmd_in && !cfg_in.single_shot |=> acq_active_out;
	endproperty
	property p_append;
		(capturing_out && acq_active_out && cfg_in.append && cfg_in.rec_type != 2'h0
			&& !start_cmd_in && !stop_cmd_in && $stable(cfg_in.rec_type))
			##0 s_fire |=> rec_done_out;
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
	a_en_load: assert property (p_en_load) else $error("enable not loaded");
	a_en_hold: assert property (p_en_hold) else $error("enable changed");
	a_start_src: assert property (p_start_src) else $error("capture without trigger");
	a_slot_rng: assert property (p_slot_rng) else $error("slot out of range");
	a_used_rng: assert property (p_used_rng) else $error("used out of range");
	a_halt_hold: assert property (p_halt_hold) else $error("halt left early");
	a_restart: assert property (p_restart) else $error("start ignored");
	a_no_halt: assert property (p_no_halt) else $error("halt in overwrite mode");
	a_append: assert property (p_append) else $error("append did not close");
endmodule
bind wcr_recorder wcr_props u_wcr_props (.mclk_in, .nrst_in, .trig_src_in, .trig_en_in,
	.trig_en_we_in, .cfg_in, .start_cmd_in, .stop_cmd_in, .acq_active_out,
	.capturing_out, .rec_done_out, .rec_slot_out, .rec_used_out, .trig_en_out);
`default_nettype wire

// File: testbench/wcr_src_model.sv
// Purpose: sample front end feeding the recorder
// Assumes: valid held until ready; sample value equals its index
// Notes:   stall_in slows the source; idle data is inverted
`default_nettype none
module wcr_src_model (
	input  wire logic            mclk_in,
	input  wire logic            nrst_in,
	input  wire logic            stall_in,
	input  wire logic [15:0]     limit_in,
	input  wire logic            ready_in,
	output logic                 valid_out,
	output wcr_pkg::wcr_sample_t samp_out,
	output logic [15:0]          sent_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt;
	assign cnt = sent_out + {15'h0000, valid_out && ready_in};
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			valid_out <= 1'b0;
			sent_out <= 16'h0000;
			samp_out <= 16'hFFFF;
		end else begin
			sent_out <= cnt;
			if (!(valid_out && !ready_in)) begin
				valid_out <= !stall_in && cnt < limit_in;
				samp_out.data <= (!stall_in && cnt < limit_in) ? cnt : ~samp_out.data;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the waveform capture recorder
// Assumes: 50 MHz clock, trigger source 0 used throughout
// Notes:   record lengths follow 128 samples per 8 power cycles
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in, nrst_in, ready, valid, stall, we, start, stop, rd_en, seen;
	logic [7:0] src, en, en_o;
	logic [9:0] rd_addr, rs;
	logic [15:0] limit, sent, rd_data;
	logic acq, capt, done;
	logic [2:0] slot;
	logic [3:0] used;
	wcr_pkg::wcr_cfg_t cfg;
	wcr_pkg::wcr_sample_t samp;
	int error_cnt, n_tests, k;
	wcr_recorder u_wcr_recorder (.mclk_in, .nrst_in, .samp_in(samp), .samp_valid_in(valid),
		.samp_ready_out(ready), .trig_src_in(src), .trig_en_in(en), .trig_en_we_in(we),
		.cfg_in(cfg), .start_cmd_in(start), .stop_cmd_in(stop), .rd_en_in(rd_en),
		.rd_addr_in(rd_addr), .rd_data_out(rd_data), .acq_active_out(acq),
		.capturing_out(capt), .rec_done_out(done), .rec_slot_out(slot),
		.rec_used_out(used), .rec_start_out(rs), .trig_en_out(en_o));
	wcr_src_model u_wcr_src_model (.mclk_in, .nrst_in, .stall_in(stall), .limit_in(limit),
		.ready_in(ready), .valid_out(valid), .samp_out(samp), .sent_out(sent));
	always #10 mclk_in = ~mclk_in;
	task automatic final_report;
		if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic bail;
		error_cnt++;
		$display("mismatch at %0t: timeout", $time);
		final_report;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic nclk(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic fire;
		@(posedge mclk_in);
		src <= 8'h01;
		@(posedge mclk_in);
		src <= 8'h00;
	endtask
	task automatic wait_done(input int n, input bit must);
		seen = 1'b0;
		for (int i = 0; i < n && !seen; i++) begin
			@(negedge mclk_in);
			stall <= (i % 7 == 3);
			seen = done;
		end
		stall <= 1'b0;
		if (must && !seen) begin
			bail;
		end
	endtask
	task automatic setup(input logic [1:0] t, input logic ss, input logic ap);
		@(posedge mclk_in);
		cfg <= '{rec_type: t, trig_pos: 8'h00, single_shot: ss, append: ap};
		start <= 1'b1;
		@(posedge mclk_in);
		start <= 1'b0;
		nclk(3);
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] exp);
		@(posedge mclk_in);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge mclk_in);
		rd_en <= 1'b0;
		@(negedge mclk_in);
		check(rd_data, exp);
	endtask
	initial begin
		{mclk_in, nrst_in, stall, we, start, stop, rd_en, src, en, rd_addr, limit} = '0;
		cfg = '{rec_type: 2'h0, trig_pos: 8'h04, single_shot: 1'b0, append: 1'b0};
		repeat (16) @(posedge mclk_in);
		nrst_in <= 1'b1;
		nclk(1);
		check(acq, 1'b1);
		check(en_o, 8'h00);
		fire;
		nclk(2);
		check(capt, 1'b0);
		@(posedge mclk_in);
		en <= 8'h01;
		we <= 1'b1;
		limit <= 16'h0028;
		@(posedge mclk_in);
		we <= 1'b0;
		for (k = 0; k < 200 && sent != 16'h0028; k++) nclk(1);
		if (sent != 16'h0028) begin
			bail;
		end
		nclk(8);
		fire;
		nclk(2);
		check(capt, 1'b1);
		check(rs, 10'h018);
		limit <= 16'hFFFF;
		wait_done(3000, 1'b1);
		nclk(2);
		check(used, 4'h1);
		check(slot, 3'h1);
		rd(10'h018, 16'h0018);
		for (int t = 0; t < 4; t++) begin
			setup(2'(t), 1'b1, 1'b0);
			k = 0;
			while (acq && k < 9) begin
				fire;
				wait_done(3000, 1'b1);
				nclk(2);
				k++;
			end
			check(16'(k), 16'(8 >> t));
			check(acq, 1'b0);
			fire;
			nclk(2);
			check(capt, 1'b0);
		end
		setup(2'h1, 1'b0, 1'b0);
		check(acq, 1'b1);
		repeat (5) begin
			fire;
			wait_done(3000, 1'b1);
			nclk(2);
		end
		check(acq, 1'b1);
		check(used, 4'h4);
		check(slot, 3'h1);
		@(posedge mclk_in);
		rd_en <= 1'b1;
		rd_addr <= 10'h000;
		nclk(6);
		check(ready, 1'b0);
		@(posedge mclk_in);
		rd_en <= 1'b0;
		nclk(2);
		check(ready, 1'b1);
		setup(2'h2, 1'b0, 1'b1);
		fire;
		nclk(10);
		fire;
		wait_done(4, 1'b0);
		check(seen, 1'b1);
		nclk(2);
		check(capt, 1'b1);
		setup(2'h0, 1'b0, 1'b1);
		fire;
		nclk(10);
		fire;
		wait_done(20, 1'b0);
		check(seen, 1'b0);
		setup(2'h1, 1'b0, 1'b0);
		fire;
		nclk(10);
		fire;
		wait_done(20, 1'b0);
		check(seen, 1'b0);
		@(posedge mclk_in);
		stop <= 1'b1;
		@(posedge mclk_in);
		stop <= 1'b0;
		nclk(1);
		check(acq, 1'b0);
		fire;
		nclk(2);
		check(capt, 1'b0);
		final_report;
	end
endmodule
`default_nettype wire
